// >>> verilog/rsd_decoder.sv
// register space decoder: module selects, flash address translation, part id, pin routing
//
// Functional notes
// - reserved writes change no state anywhere
// - reserved reads return all zeros
// - no module select for reserved ranges
// - port block: 0x0000-0x0009, 0x000C-0x000D, 0x001C-0x001F and 0x0240-0x027F
// - memory control: 0x000A-0x000B and 0x0010-0x0017
// - clock/power: 0x0034-0x003F and 0x02F0-0x02FF
// - converter window 0x0070, 48 bytes
// - pulse modulator window 0x00A0, 40 bytes
// - serial block window 0x00C8, 8 bytes
// - spi window 0x00D8, 8 bytes
// - paged flash window 0x8000-0xBFFF via page select
// - data flash 0x0400-0x13FF to 0x0_4400
// - unpaged flash to 0x3_4000 and 0x3_C000
// - part id high 0x001A, low 0x001B, read-only
// - part id constant per silicon revision
// - id bits 15-12 major, 11-6 minor family
// - id bits 5-4 major, 3-0 minor mask
// - version word lives in flash, not here
// - pulse channels 0,4,5 routable to timer pins
`timescale 1ns/1ps
`default_nettype none
`include "rsd_cfg.svh"

module rsd_decoder
  import rsd_pkg::*;
#(
  // identification fields, values arbitrary
  parameter logic [3:0] ID_MAJOR_FAMILY = 4'h1,
  parameter logic [5:0] ID_MINOR_FAMILY = 6'h02,
  parameter logic [1:0] ID_MAJOR_MASK   = 2'h0,
  parameter logic [3:0] ID_MINOR_MASK   = 4'h1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // peripheral strobes and read data
  output rsd_periph_s      periph_q,
  input  wire rsd_rdata_t  periph_rdata,
  // flash address translation
  input  wire logic        xlate_req,
  input  wire logic [15:0] xlate_addr,
  output rsd_xlate_s       xlate_q,
  // pin routing
  input  wire logic [7:0]  timer_ch_out,
  input  wire logic [7:0]  timer_ch_en,
  input  wire logic [5:0]  pulse_ch_out,
  input  wire logic [5:0]  pulse_ch_en,
  output logic      [7:0]  timer_port_pin_out,
  output logic      [7:0]  timer_port_pin_oe_n,
  // page select readback
  output logic      [7:0]  flash_page_select
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // one owner per address, none for reserved space
  function automatic rsd_mod_e decode(input logic [15:0] a);
    decode = MOD_NONE;
    if (in_rng(a, `RSD_PORT_A_LO, `RSD_PORT_A_HI) ||
        in_rng(a, `RSD_PORT_B_LO, `RSD_PORT_B_HI) ||
        in_rng(a, `RSD_PORT_C_LO, `RSD_PORT_C_HI) ||
        in_rng(a, `RSD_PORT_D_LO, `RSD_PORT_D_HI)) begin
      decode = MOD_PORT;
    end else if (in_rng(a, `RSD_MEM_A_LO, `RSD_MEM_A_HI) ||
                 in_rng(a, `RSD_MEM_B_LO, `RSD_MEM_B_HI)) begin
      decode = MOD_MEMCTL;
    end else if (in_rng(a, `RSD_ID_HIGH, `RSD_ID_LOW)) begin
      decode = MOD_ID;
    end else if (in_rng(a, `RSD_DEBUG_LO, `RSD_DEBUG_HI)) begin
      decode = MOD_DEBUG;
    end else if (in_rng(a, `RSD_CLK_A_LO, `RSD_CLK_A_HI) ||
                 in_rng(a, `RSD_CLK_B_LO, `RSD_CLK_B_HI)) begin
      decode = MOD_CLKPWR;
    end else if (in_rng(a, `RSD_TIMER_LO, `RSD_TIMER_HI)) begin
      decode = MOD_TIMER;
    end else if (in_rng(a, `RSD_ADC_LO, `RSD_ADC_HI)) begin
      decode = MOD_ADC;
    end else if (in_rng(a, `RSD_PULSE_LO, `RSD_PULSE_HI)) begin
      decode = MOD_PULSE;
    end else if (in_rng(a, `RSD_UART_LO, `RSD_UART_HI)) begin
      decode = MOD_UART;
    end else if (in_rng(a, `RSD_SPI_LO, `RSD_SPI_HI)) begin
      decode = MOD_SPI;
    end else if (in_rng(a, `RSD_NVM_LO, `RSD_NVM_HI)) begin
      decode = MOD_NVMCTL;
    end else if (a == `RSD_INTC_ADDR) begin
      decode = MOD_INTC;
    end else if (in_rng(a, `RSD_CAN_LO, `RSD_CAN_HI)) begin
      decode = MOD_CAN;
    end else begin
      decode = MOD_NONE;
    end
  endfunction : decode

  // local to global address
  function automatic rsd_xlate_s translate(input logic [15:0] a, input logic [7:0] page);
    rsd_xlate_s res;
    res.valid = 1'b1;
    res.kind  = XK_NONE;
    res.gaddr = 18'h00000;
    case (a[15:14])
      2'b00: begin
        if (a <= `RSD_REG_TOP) begin
          res.kind  = XK_REG;
          res.gaddr = {2'b00, a};
        end else if (in_rng(a, `RSD_DFLASH_LO, `RSD_DFLASH_HI)) begin
          res.kind  = XK_DFLASH;
          res.gaddr = {2'b00, a} + `RSD_DFLASH_OFS;
        end else if (in_rng(a, `RSD_RAM_LO, `RSD_RAM_HI)) begin
          res.kind  = XK_RAM;
          res.gaddr = `RSD_RAM_BASE | {2'b00, a};
        end else begin
          res.kind  = XK_NONE;
        end
      end
      2'b01: begin
        res.kind  = XK_PF_UNPAGED;
        res.gaddr = {`RSD_UNP_LOW_TAG, a[13:0]};
      end
      2'b10: begin
        res.kind  = XK_PF_PAGED;
        res.gaddr = {page[3:0], a[13:0]};
      end
      default: begin
        res.kind  = XK_PF_UNPAGED;
        res.gaddr = {`RSD_UNP_HIGH_TAG, a[13:0]};
      end
    endcase
    return res;
  endfunction : translate

  ////////////////////////////////////////////////////////////////////////////
  // part identification

  // fixed per revision; version word is kept in flash, not here
  localparam logic [15:0] PART_ID = (16'(ID_MAJOR_FAMILY) << `RSD_ID_MAJ_POS)
                                  | (16'(ID_MINOR_FAMILY) << `RSD_ID_MIN_POS)
                                  | (16'(ID_MAJOR_MASK) << `RSD_ID_MMAJ_POS)
                                  | 16'(ID_MINOR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  rsd_mod_e     mod_sel;
  logic [13:0]  sel_vec;
  logic         hit_page;
  logic         hit_route;

  always_comb begin
    mod_sel = decode(reg_addr);
    sel_vec = 14'h0000;
    if (mod_sel != MOD_NONE && mod_sel != MOD_ID) begin
      sel_vec[mod_sel] = 1'b1;
    end
  end

  assign hit_page  = (reg_addr == `RSD_PAGE_ADDR);
  assign hit_route = (reg_addr == `RSD_ROUTE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // peripheral strobes

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      periph_q <= '0;
    end else begin
      periph_q.sel   <= (reg_wr || reg_rd) ? sel_vec : 14'h0000;
      periph_q.wr    <= reg_wr && (sel_vec != 14'h0000);
      periph_q.rd    <= reg_rd && (sel_vec != 14'h0000);
      // payload moves only on an access that some module owns
      if ((reg_wr || reg_rd) && (sel_vec != 14'h0000)) begin
        periph_q.addr  <= reg_addr;
        periph_q.wdata <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local control registers

  logic [7:0] page_q;
  logic [7:0] route_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      page_q <= `RSD_PAGE_RESET;
    end else if (reg_wr && hit_page) begin
      page_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      route_q <= `RSD_ROUTE_RESET;
    end else if (reg_wr && hit_route) begin
      route_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_page_select <= `RSD_PAGE_RESET;
    end else if (reg_wr && hit_page) begin
      flash_page_select <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit_page) begin
        reg_rdata <= page_q;
      end else if (hit_route) begin
        reg_rdata <= route_q;
      end else begin
        case (mod_sel)
          MOD_NONE: begin
            reg_rdata <= 8'h00;
          end
          MOD_ID: begin
            reg_rdata <= reg_addr[0] ? PART_ID[7:0] : PART_ID[15:8];
          end
          default: begin
            reg_rdata <= periph_rdata[mod_sel];
          end
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash address translation

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xlate_q <= '0;
    end else if (xlate_req) begin
      xlate_q <= translate(xlate_addr, page_q);
    end else begin
      xlate_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer port pin routing

  logic [7:0] pin_val;
  logic [7:0] pin_en;

  always_comb begin
    pin_val = timer_ch_out;
    pin_en  = timer_ch_en;
    if (route_q[0]) begin
      pin_val[0] = pulse_ch_out[0];
      pin_en[0]  = pulse_ch_en[0];
    end
    if (route_q[4]) begin
      pin_val[4] = pulse_ch_out[4];
      pin_en[4]  = pulse_ch_en[4];
    end
    if (route_q[5]) begin
      pin_val[5] = pulse_ch_out[5];
      pin_en[5]  = pulse_ch_en[5];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_port_pin_out  <= 8'h00;
      timer_port_pin_oe_n <= 8'hFF;
    end else begin
      timer_port_pin_out  <= pin_val;
      timer_port_pin_oe_n <= ~pin_en;
    end
  end

endmodule : rsd_decoder

`default_nettype wire

// >>> include/rsd_cfg.svh
// register space decoder: offsets, field positions, reset values
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH
`define RSD_REG_TOP       16'h03FF
`define RSD_PORT_A_LO     16'h0000
`define RSD_PORT_A_HI     16'h0009
`define RSD_MEM_A_LO      16'h000A
`define RSD_MEM_A_HI      16'h000B
`define RSD_PORT_B_LO     16'h000C
`define RSD_PORT_B_HI     16'h000D
`define RSD_MEM_B_LO      16'h0010
`define RSD_MEM_B_HI      16'h0017
`define RSD_ID_HIGH       16'h001A
`define RSD_ID_LOW        16'h001B
`define RSD_PORT_C_LO     16'h001C
`define RSD_PORT_C_HI     16'h001F
`define RSD_DEBUG_LO      16'h0020
`define RSD_DEBUG_HI      16'h002F
`define RSD_CLK_A_LO      16'h0034
`define RSD_CLK_A_HI      16'h003F
`define RSD_TIMER_LO      16'h0040
`define RSD_TIMER_HI      16'h006F
`define RSD_ADC_LO        16'h0070
`define RSD_ADC_HI        16'h009F
`define RSD_PULSE_LO      16'h00A0
`define RSD_PULSE_HI      16'h00C7
`define RSD_UART_LO       16'h00C8
`define RSD_UART_HI       16'h00CF
`define RSD_SPI_LO        16'h00D8
`define RSD_SPI_HI        16'h00DF
`define RSD_NVM_LO        16'h0100
`define RSD_NVM_HI        16'h0113
`define RSD_INTC_ADDR     16'h0120
`define RSD_CAN_LO        16'h0140
`define RSD_CAN_HI        16'h017F
`define RSD_PORT_D_LO     16'h0240
`define RSD_PORT_D_HI     16'h027F
`define RSD_CLK_B_LO      16'h02F0
`define RSD_CLK_B_HI      16'h02FF
`define RSD_PAGE_ADDR     16'h0015
`define RSD_ROUTE_ADDR    16'h027F
`define RSD_PAGE_RESET    8'h0F
`define RSD_ROUTE_RESET   8'h00
`define RSD_DFLASH_LO     16'h0400
`define RSD_DFLASH_HI     16'h13FF
`define RSD_DFLASH_OFS    18'h04000
`define RSD_RAM_LO        16'h1400
`define RSD_RAM_HI        16'h27FF
`define RSD_RAM_BASE      18'h30000
`define RSD_UNP_LOW_TAG   4'hD
`define RSD_UNP_HIGH_TAG  4'hF
`define RSD_ID_MAJ_POS    12
`define RSD_ID_MIN_POS    6
`define RSD_ID_MMAJ_POS   4
`endif

// >>> include/rsd_pkg.sv
// register space decoder: shared types
package rsd_pkg;
  typedef enum logic [3:0] {
    MOD_NONE   = 4'h0, MOD_PORT  = 4'h1, MOD_MEMCTL = 4'h2, MOD_ID   = 4'h3,
    MOD_DEBUG  = 4'h4, MOD_CLKPWR = 4'h5, MOD_TIMER = 4'h6, MOD_ADC  = 4'h7,
    MOD_PULSE  = 4'h8, MOD_UART  = 4'h9, MOD_SPI    = 4'hA, MOD_NVMCTL = 4'hB,
    MOD_INTC   = 4'hC, MOD_CAN   = 4'hD
  } rsd_mod_e;
  typedef enum logic [2:0] {
    XK_NONE = 3'h0, XK_REG = 3'h1, XK_DFLASH = 3'h2, XK_RAM = 3'h3,
    XK_PF_UNPAGED = 3'h4, XK_PF_PAGED = 3'h5
  } rsd_kind_e;
  typedef struct packed {
    logic [13:0] sel;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rsd_periph_s;
  typedef struct packed {
    logic        valid;
    rsd_kind_e   kind;
    logic [17:0] gaddr;
  } rsd_xlate_s;
  typedef logic [13:0][7:0] rsd_rdata_t;
endpackage : rsd_pkg

// >>> testbench/rsd_decoder_sva.sv
// checker for the register space decoder ports
`timescale 1ns/1ps
`default_nettype none
module rsd_decoder_sva
  import rsd_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire rsd_periph_s periph_q,
  // translation
  input wire logic        xlate_req,
  input wire logic [15:0] xlate_addr,
  input wire rsd_xlate_s  xlate_q,
  input wire logic [7:0]  flash_page_select
);
  logic       acc;
  logic [3:0] pg_q;
  logic [15:0] xa_q;
  assign acc = reg_wr | reg_rd;
  always_ff @(posedge clock) begin
    pg_q <= flash_page_select[3:0];
    xa_q <= xlate_addr;
  end
  function automatic logic rsv(input logic [15:0] a);
    return a inside {[16'h000E:16'h000F], [16'h0018:16'h0019], [16'h0030:16'h0033], [16'h00D0:16'h00D7],
                     [16'h00E0:16'h00FF], [16'h0114:16'h011F], [16'h0121:16'h013F], [16'h0180:16'h023F],
                     [16'h0280:16'h02EF], [16'h0300:16'h03FF]};
  endfunction : rsv
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_one_select: assert property ($onehot0(periph_q.sel))
    else $error("more than one select");
  chk_rsvd_nosel: assert property (acc && rsv(reg_addr) |=> periph_q.sel == 14'h0000)
    else $error("select on reserved");
  chk_rsvd_hold: assert property (reg_wr && rsv(reg_addr)
    |=> $stable(periph_q.addr) && $stable(periph_q.wdata))
    else $error("reserved write moved payload");
  chk_rsvd_zero: assert property (reg_rd && rsv(reg_addr) |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  chk_port_sel: assert property (acc && reg_addr inside {[16'h0000:16'h0009], [16'h0240:16'h027F]}
    |=> periph_q.sel[1])
    else $error("port select missing");
  chk_mem_sel: assert property (acc && reg_addr inside {[16'h000A:16'h000B], [16'h0010:16'h0017]}
    |=> periph_q.sel[2])
    else $error("memory control select missing");
  chk_clk_sel: assert property (acc && reg_addr inside {[16'h0034:16'h003F], [16'h02F0:16'h02FF]}
    |=> periph_q.sel[5])
    else $error("clock select missing");
  chk_adc_sel: assert property (acc && reg_addr inside {[16'h0070:16'h009F]} |=> periph_q.sel[7])
    else $error("converter select missing");
  chk_pulse_sel: assert property (acc && reg_addr inside {[16'h00A0:16'h00C7]} |=> periph_q.sel[8])
    else $error("pulse select missing");
  chk_dflash_map: assert property (xlate_req && xlate_addr inside {[16'h0400:16'h13FF]}
    |=> xlate_q.gaddr == {2'b00, xa_q} + 18'h04000)
    else $error("data flash address wrong");
  chk_page_map: assert property (xlate_req && xlate_addr[15:14] == 2'b10
    |=> xlate_q.gaddr == {pg_q, xa_q[13:0]})
    else $error("paged address wrong");
  chk_unpaged_map: assert property (xlate_req && xlate_addr[14]
    |=> xlate_q.gaddr == {2'b11, xa_q})
    else $error("unpaged address wrong");
  cov_write: cover property (reg_wr ##1 periph_q.wr);
  cov_id_read: cover property (reg_rd && reg_addr == 16'h001A);
  cov_xlate: cover property (xlate_q.valid);
endmodule : rsd_decoder_sva
bind rsd_decoder rsd_decoder_sva i_rsd_decoder_sva (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_q(periph_q), .xlate_req(xlate_req),
  .xlate_addr(xlate_addr), .xlate_q(xlate_q), .flash_page_select(flash_page_select));
`default_nettype wire

// >>> testbench/rsd_periph_model.sv
// peripheral read data model: each module answers a byte of its own
`timescale 1ns/1ps
`default_nettype none
module rsd_periph_model
  import rsd_pkg::*;
(
  // read data per module
  output rsd_rdata_t rdata
);
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      rdata[i] = 8'hA0 | 8'(i);
    end
  end
endmodule : rsd_periph_model
`default_nettype wire

// >>> testbench/register_space_address_decoder_tb_top.sv
// testbench for the register space decoder
`timescale 1ns/1ps
`default_nettype none
module register_space_address_decoder_tb_top
  import rsd_pkg::*;
;
  localparam logic [15:0] PART_ID = {4'h1, 6'h02, 2'h0, 4'h1};
  logic        clock, rst, reg_wr, reg_rd, xlate_req;
  logic [15:0] reg_addr, xlate_addr;
  logic [7:0]  reg_wdata, reg_rdata, timer_ch_out, timer_ch_en, pin_out, pin_oe_n, page;
  logic [5:0]  pulse_ch_out, pulse_ch_en;
  rsd_periph_s periph;
  rsd_xlate_s  xq;
  rsd_rdata_t  prd;
  logic [19:0] tbl [16];
  int          fails, check_count;
  rsd_decoder #(.ID_MAJOR_FAMILY(4'h1), .ID_MINOR_FAMILY(6'h02), .ID_MAJOR_MASK(2'h0), .ID_MINOR_MASK(4'h1))
  i_rsd_decoder (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_q(periph), .periph_rdata(prd), .xlate_req(xlate_req),
    .xlate_addr(xlate_addr), .xlate_q(xq), .timer_ch_out(timer_ch_out), .timer_ch_en(timer_ch_en),
    .pulse_ch_out(pulse_ch_out), .pulse_ch_en(pulse_ch_en), .timer_port_pin_out(pin_out),
    .timer_port_pin_oe_n(pin_oe_n), .flash_page_select(page));
  rsd_periph_model i_rsd_periph_model (.rdata(prd));
  ////////////////////////////////////////
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : acc
  task xl(input logic [15:0] a, input logic [17:0] e, input rsd_kind_e k);
    @(posedge clock);
    xlate_req <= 1'b1;
    xlate_addr <= a;
    @(posedge clock);
    xlate_req <= 1'b0;
    #1;
    chk(xq.gaddr, e);
    chk({xq.valid, xq.kind}, {1'b1, k});
  endtask : xl
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {rst, reg_wr, reg_rd, xlate_req, reg_addr, xlate_addr, reg_wdata} = {4'h8, 40'h0};
    {timer_ch_out, timer_ch_en, pulse_ch_out, pulse_ch_en} = 28'h0;
    fails = 0;
    check_count = 0;
    tbl = '{{16'h0000, 4'h1}, {16'h0009, 4'h1}, {16'h0240, 4'h1}, {16'h000A, 4'h2}, {16'h0017, 4'h2},
            {16'h0034, 4'h5}, {16'h02FF, 4'h5}, {16'h009F, 4'h7}, {16'h00C7, 4'h8}, {16'h00C8, 4'h9},
            {16'h00DF, 4'hA}, {16'h000E, 4'h0}, {16'h0030, 4'h0}, {16'h00D0, 4'h0}, {16'h0280, 4'h0},
            {16'h03FF, 4'h0}};
    repeat (20) @(posedge clock);
    chk(page, 8'h0F);
    chk(pin_oe_n, 8'hFF);
    rst <= 1'b0;
    foreach (tbl[i]) begin
      acc(1'b0, tbl[i][19:4], 8'h00);
      chk(periph.sel, tbl[i][3:0] == 4'h0 ? 14'h0 : 14'h1 << tbl[i][3:0]);
    end
    $display("select test done");
    acc(1'b0, 16'h001A, 8'h00);
    chk(reg_rdata, PART_ID[15:8]);
    acc(1'b0, 16'h001B, 8'h00);
    chk(reg_rdata, PART_ID[7:0]);
    acc(1'b1, 16'h001A, 8'h55);
    acc(1'b0, 16'h001A, 8'h00);
    chk(reg_rdata, PART_ID[15:8]);
    acc(1'b0, 16'h00D4, 8'h00);
    chk(reg_rdata, 8'h00);
    acc(1'b0, 16'h00A0, 8'h00);
    chk(reg_rdata, 8'hA8);
    chk({periph.wr, periph.rd, periph.sel}, {2'b01, 14'h0100});
    acc(1'b1, 16'h00A0, 8'h5A);
    chk({periph.wr, periph.rd, periph.sel}, {2'b10, 14'h0100});
    chk(periph.addr, 16'h00A0);
    chk(periph.wdata, 8'h5A);
    acc(1'b1, 16'h0018, 8'h03);
    chk(periph.sel, 14'h0);
    chk({periph.wr, periph.wdata}, {1'b0, 8'h5A});
    chk(periph.addr, 16'h00A0);
    chk(page, 8'h0F);
    $display("register test done");
    xl(16'h8123, 18'h3C123, XK_PF_PAGED);
    acc(1'b1, 16'h0015, 8'h05);
    chk(page, 8'h05);
    acc(1'b0, 16'h0015, 8'h00);
    chk(reg_rdata, 8'h05);
    xl(16'h8000, 18'h14000, XK_PF_PAGED);
    xl(16'h0400, 18'h04400, XK_DFLASH);
    xl(16'h13FF, 18'h053FF, XK_DFLASH);
    xl(16'h4000, 18'h34000, XK_PF_UNPAGED);
    xl(16'hFFFF, 18'h3FFFF, XK_PF_UNPAGED);
    xl(16'h1400, 18'h31400, XK_RAM);
    xl(16'h0120, 18'h00120, XK_REG);
    xl(16'h3000, 18'h00000, XK_NONE);
    $display("translation test done");
    @(posedge clock);
    timer_ch_en <= 8'hFF;
    pulse_ch_en <= 6'h3F;
    pulse_ch_out <= 6'h31;
    acc(1'b1, 16'h027F, 8'h31);
    repeat (2) @(posedge clock);
    #1;
    chk(pin_out, 8'h31);
    chk(pin_oe_n, 8'h00);
    $display("routing test done");
    give_verdict;
  end
endmodule : register_space_address_decoder_tb_top
`default_nettype wire
